//--- verif/otpsa_cell_model.sv
// macrocell partner: answers each word request after a set delay
module otpsa_cell_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cell_req,
   input wire logic [7:0] delay,
   output logic cell_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] wait_cnt;
   // one answer per request, silent while no request stands
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_cnt <= 8'h00;
      end else begin
         wait_cnt <= (cell_req && !cell_done) ? wait_cnt + 8'h01 : 8'h00;
      end
   end
   assign cell_done = cell_req && (wait_cnt == delay);
endmodule // otpsa_cell_model

//--- verif/otpsa_status_monitor.sv
// assertion checker for the otp status block ports
module otpsa_status_monitor (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic cell_req,
   input wire logic cell_done,
   input wire logic cell_write,
   input wire logic [12:0] cell_addr,
   input wire logic [31:0] dma_addr,
   input wire logic [2:0] mode
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
   aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address accepted");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   // an abort through standby may drop a request without an answer
   cell_hold_a: assert property (cell_req && !cell_done |=>
      (cell_req && $stable(cell_addr)) || mode == 3'h0) else $error("request dropped");
   cell_step_a: assert property (cell_req && cell_done |=>
      !cell_req && cell_addr == $past(cell_addr) + 13'h1) else $error("address not advanced");
   dma_align_a: assert property (dma_addr[1:0] == 2'h0)
      else $error("dma address not word aligned");
   mode_path_a: assert property ($changed(mode) && $past(mode) != 3'h0 |-> mode == 3'h0)
      else $error("mode changed without standby");
   mode_code_a: assert property (mode <= 3'h4)
      else $error("reserved mode code");
   write_kind_a: assert property (cell_req && mode != 3'h0 |-> cell_write == (mode == 3'h4))
      else $error("request kind does not match mode");
endmodule // otpsa_status_monitor

bind otpsa_status otpsa_status_monitor otpsa_status_monitor_inst (.clk, .reset_n,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .cell_req, .cell_done, .cell_write, .cell_addr, .dma_addr, .mode);

//--- verif/testbench.sv
// self-checking bench for the otp status block
`include "otpsa_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF, fifo_level = 4'h3;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, mirror_active = 1'h0;
   logic prog_busy = 1'h0, prog_result_valid = 1'h0, prog_fail_upper = 1'h0;
   logic test_busy = 1'h0, test_result_valid = 1'h0, test_fail_lower = 1'h0;
   logic prog_fail_lower = 1'h0, test_fail_upper = 1'h0;
   logic [7:0] delay = 8'h14;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, dma_addr;
   wire cell_req, cell_write, cell_done, irq;
   wire [12:0] cell_addr;
   wire [2:0] mode;
   logic [31:0] rd;
   logic [1:0] rsp;
   logic irq_a;
   integer mismatches = 0, n_checks = 0, cyc = 0;

   otpsa_status otpsa_status_inst (.*);
   otpsa_cell_model otpsa_cell_model_inst (.*);

   always #5 clk = ~clk;

   // ------------------------------------------------------------
   // bus tasks and checks
   // ------------------------------------------------------------
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         give_verdict;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask

   task automatic rr(input logic [31:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic rc(input logic [31:0] a, input logic [31:0] e);
      rr(a);
      chk(rd, e);
   endtask

   task automatic wrc(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
      wr(a, d);
      rc(a, e);
   endtask

   // polls until the automatic run reports idle
   task automatic wait_auto;
      do rr(`OTPSA_ADDR_STATUS); while (rd[4] !== 1'h1);
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      rc(`OTPSA_ADDR_STATUS, 32'h00000315);
      rc(`OTPSA_ADDR_DMA_BASE, 32'h0);
      rc(`OTPSA_ADDR_CELL_ADDR, 32'h0);
      rc(`OTPSA_ADDR_XFER_LEN, 32'h0);
      rc(32'h40008000, 32'h0);
      chk({30'h0, rsp}, {30'h0, `OTPSA_RESP_SLVERR});
      wrc(`OTPSA_ADDR_DMA_BASE, 32'hFFFFFFFF, 32'hFFFFFFFC);
      wrc(`OTPSA_ADDR_CELL_ADDR, 32'hFFFFFFFF, 32'h00001FFF);
      wrc(`OTPSA_ADDR_XFER_LEN, 32'hFFFFFFFF, 32'h00001FFF);
      wrc(`OTPSA_ADDR_STATUS, 32'hFFFFFFFF, 32'h00000315);
      // three words across the top of the address range
      wr(`OTPSA_ADDR_XFER_LEN, 32'h2);
      wr(`OTPSA_ADDR_CELL_ADDR, 32'h1FFE);
      wr(`OTPSA_ADDR_CONTROL, {29'h0, `OTPSA_MODE_AUTO_READ});
      rc(`OTPSA_ADDR_STATUS, 32'h00030305);
      wait_auto;
      chk(rd, 32'h00000315);
      rc(`OTPSA_ADDR_CELL_ADDR, 32'h1);
      rc(`OTPSA_ADDR_XFER_LEN, 32'h2);
      wr(`OTPSA_ADDR_CONTROL, {29'h0, `OTPSA_MODE_AUTO_PROG});
      chk({29'h0, mode}, {29'h0, `OTPSA_MODE_AUTO_READ});
      for (int m = 1; m < 3; m++) begin
         wr(`OTPSA_ADDR_CONTROL, 32'h0);
         wr(`OTPSA_ADDR_CONTROL, m);
         chk({29'h0, mode}, m);
      end
      wr(`OTPSA_ADDR_CONTROL, 32'h0);
      wr(`OTPSA_ADDR_CONTROL, 32'h5);
      chk({29'h0, mode}, 32'h0);
      delay <= 8'h00;
      mirror_active <= 1'h1;
      wr(`OTPSA_ADDR_XFER_LEN, 32'h1);
      wr(`OTPSA_ADDR_CONTROL, {29'h0, `OTPSA_MODE_AUTO_READ});
      wait_auto;
      rc(`OTPSA_ADDR_XFER_LEN, 32'h0);
      mirror_active <= 1'h0;
      wr(`OTPSA_ADDR_CONTROL, 32'h0);
      delay <= 8'h03;
      wr(`OTPSA_ADDR_XFER_LEN, 32'h5);
      wr(`OTPSA_ADDR_CONTROL, 32'hC);
      rr(`OTPSA_ADDR_STATUS);
      chk(rd & 32'h1FFF0010, 32'h0);
      wr(`OTPSA_ADDR_CONTROL, 32'h0);
      rc(`OTPSA_ADDR_XFER_LEN, 32'h5);
      fifo_level <= `OTPSA_FIFO_FULL;
      wr(`OTPSA_ADDR_XFER_LEN, 32'h0);
      wr(`OTPSA_ADDR_CONTROL, {29'h0, `OTPSA_MODE_AUTO_READ});
      repeat (8) @(posedge clk);
      chk({31'h0, cell_req}, 32'h0);
      rc(`OTPSA_ADDR_STATUS, 32'h00010F05);
      fifo_level <= 4'h3;
      wait_auto;
      prog_busy <= 1'h1;
      test_busy <= 1'h1;
      rc(`OTPSA_ADDR_STATUS, 32'h00000310);
      prog_result_valid <= 1'h1;
      prog_fail_upper <= 1'h1;
      test_result_valid <= 1'h1;
      test_fail_lower <= 1'h1;
      prog_busy <= 1'h0;
      test_busy <= 1'h0;
      @(posedge clk);
      prog_result_valid <= 1'h0;
      test_result_valid <= 1'h0;
      rr(`OTPSA_ADDR_STATUS);
      chk(rd[0], 1'h1);
      chk(rd, 32'h0000631F);
      rc(`OTPSA_ADDR_IRQ_STATUS, 32'h7);
      wr(`OTPSA_ADDR_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk);
      irq_a = irq;
      wr(`OTPSA_ADDR_IRQ_MASK, 32'h7);
      repeat (2) @(posedge clk);
      chk({31'h0, irq_a}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      wr(`OTPSA_ADDR_IRQ_STATUS, 32'h7);
      rc(`OTPSA_ADDR_IRQ_STATUS, 32'h0);
      chk({31'h0, irq}, 32'h0);
      give_verdict;
   end
endmodule // testbench

//--- verilog/otpsa_map.vh
// register map, field positions, reset values and codes of the otp status block
`ifndef OTPSA_MAP_VH
`define OTPSA_MAP_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define OTPSA_ADDR_STATUS 32'h40008008
`define OTPSA_ADDR_DMA_BASE 32'h4000800C
`define OTPSA_ADDR_CELL_ADDR 32'h40008010
`define OTPSA_ADDR_XFER_LEN 32'h40008014
`define OTPSA_ADDR_CONTROL 32'h40008040
`define OTPSA_ADDR_IRQ_STATUS 32'h40008044
`define OTPSA_ADDR_IRQ_MASK 32'h40008048

// ---------------------------------------------------------------
// controller_status fields
// ---------------------------------------------------------------
`define OTPSA_ST_WORDS_HI 28
`define OTPSA_ST_WORDS_LO 16
`define OTPSA_ST_UP_TEST 15
`define OTPSA_ST_LO_TEST 14
`define OTPSA_ST_UP_PROG 13
`define OTPSA_ST_LO_PROG 12
`define OTPSA_ST_FIFO_HI 11
`define OTPSA_ST_FIFO_LO 8
`define OTPSA_ST_AUTO_IDLE 4
`define OTPSA_ST_TEST_FAIL 3
`define OTPSA_ST_TEST_IDLE 2
`define OTPSA_ST_PROG_FAIL 1
`define OTPSA_ST_BITPROG_IDLE 0

// ---------------------------------------------------------------
// control fields, modes, interrupt bits
// ---------------------------------------------------------------
`define OTPSA_CTL_MODE_HI 2
`define OTPSA_CTL_MODE_LO 0
`define OTPSA_CTL_PORT_SEL 3
`define OTPSA_MODE_STANDBY 3'h0
`define OTPSA_MODE_MAN_READ 3'h1
`define OTPSA_MODE_MAN_PROG 3'h2
`define OTPSA_MODE_AUTO_READ 3'h3
`define OTPSA_MODE_AUTO_PROG 3'h4
`define OTPSA_IRQ_AUTO_DONE 0
`define OTPSA_IRQ_PROG_FAIL 1
`define OTPSA_IRQ_TEST_FAIL 2
`define OTPSA_FIFO_FULL 4'hF

// ---------------------------------------------------------------
// reset values and bus answers
// ---------------------------------------------------------------
`define OTPSA_RST_IDLE 1'h1
`define OTPSA_RST_ZERO 32'h00000000
`define OTPSA_RESP_OKAY 2'h0
`define OTPSA_RESP_SLVERR 2'h2

`endif

//--- verilog/otpsa_status.v
// otp controller status, addressing and word-count block with axi4-lite slave
// What this block does
// - status 28:16 shows words still to process
// - bits 15/14 flag upper/lower bank test error
// - bits 13/12 flag upper/lower bank program error
// - bits 11:8 show fifo word occupancy
// - bit 4 low while auto op runs
// - bit 3 gives last test pass/fail
// - bit 2 low while test mode runs
// - bit 1 set when bit-programming failed
// - bit 0 low while bit-programming busy
// - dma base address register, bits 31:2
// - 13-bit cell address, auto-advanced per word
// - 13-bit transfer length, count minus one
// - port-select auto program ignores transfer length
// - length shows remaining while mirroring, else held
// - mode codes; switches pass through standby
`include "otpsa_map.vh"

module otpsa_status (
   input wire clk,
   input wire reset_n,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [3:0] fifo_level,
   input wire cell_done,
   input wire prog_busy,
   input wire prog_result_valid,
   input wire prog_fail_upper,
   input wire prog_fail_lower,
   input wire test_busy,
   input wire test_result_valid,
   input wire test_fail_upper,
   input wire test_fail_lower,
   input wire mirror_active,
   output reg cell_req,
   output reg cell_write,
   output reg [12:0] cell_addr,
   output reg [31:0] dma_addr,
   output reg [2:0] mode,
   output reg irq
);

   localparam S_IDLE = 1'b0;
   localparam S_RUN = 1'b1;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [31:0] merge;
      input [31:0] old;
      input [31:0] din;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = din[i*8 +: 8];
            end
         end
      end
   endfunction

   function mapped;
      input [31:0] a;
      begin
         mapped = (a == `OTPSA_ADDR_STATUS) || (a == `OTPSA_ADDR_DMA_BASE) ||
            (a == `OTPSA_ADDR_CELL_ADDR) || (a == `OTPSA_ADDR_XFER_LEN) ||
            (a == `OTPSA_ADDR_CONTROL) || (a == `OTPSA_ADDR_IRQ_STATUS) ||
            (a == `OTPSA_ADDR_IRQ_MASK);
      end
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg [31:0] aw_addr;
   reg aw_full;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_full;
   reg [12:0] xfer_len;
   reg port_sel;
   reg state;
   reg [13:0] remaining;
   reg auto_idle;
   reg bitprog_idle;
   reg test_idle;
   reg prog_fail_flag;
   reg upper_prog_fail;
   reg lower_prog_fail;
   reg test_fail_flag;
   reg upper_test_fail;
   reg lower_test_fail;
   reg [3:0] fifo_words;
   reg [2:0] irq_status;
   reg [2:0] irq_mask;

   wire do_write = aw_full && w_full && !s_axi_bvalid;
   wire [31:0] wr_val = merge(`OTPSA_RST_ZERO, w_data, w_strb);
   // the low two address bits are never stored, so dma stays word aligned
   wire [31:0] dma_merged = merge(dma_addr, w_data, w_strb);
   wire [31:0] len_merged = merge({19'h0, xfer_len}, w_data, w_strb);
   wire wr_ctl = do_write && (aw_addr == `OTPSA_ADDR_CONTROL);
   wire [2:0] new_mode = wr_val[`OTPSA_CTL_MODE_HI:`OTPSA_CTL_MODE_LO];
   wire new_port_sel = wr_val[`OTPSA_CTL_PORT_SEL];
   // reserved test codes are refused, a direct hop between working modes too
   wire mode_ok = (new_mode <= `OTPSA_MODE_AUTO_PROG) &&
      ((mode == `OTPSA_MODE_STANDBY) || (new_mode == `OTPSA_MODE_STANDBY));
   wire mode_chg = wr_ctl && mode_ok && (new_mode != mode);
   wire start_auto = mode_chg && ((new_mode == `OTPSA_MODE_AUTO_READ) ||
      (new_mode == `OTPSA_MODE_AUTO_PROG));
   wire prog_via_port = port_sel && (mode == `OTPSA_MODE_AUTO_PROG);
   wire fifo_ok = cell_write ? (fifo_words != 4'h0) : (fifo_words != `OTPSA_FIFO_FULL);
   wire word_done = (state == S_RUN) && cell_req && cell_done;
   wire last_word = (remaining == 14'h0001) && !prog_via_port;
   wire [2:0] events;

   assign events[`OTPSA_IRQ_AUTO_DONE] = word_done && last_word;
   assign events[`OTPSA_IRQ_PROG_FAIL] = prog_result_valid && (prog_fail_upper || prog_fail_lower);
   assign events[`OTPSA_IRQ_TEST_FAIL] = test_result_valid && (test_fail_upper || test_fail_lower);

   // ---------------------------------------------------------------
   // read mux, no side effects on any flag
   // ---------------------------------------------------------------
   reg [31:0] rd_val;
   always @* begin
      rd_val = `OTPSA_RST_ZERO;
      case (s_axi_araddr)
         `OTPSA_ADDR_STATUS: begin
            rd_val[`OTPSA_ST_WORDS_HI:`OTPSA_ST_WORDS_LO] = remaining[12:0];
            rd_val[`OTPSA_ST_UP_TEST] = upper_test_fail;
            rd_val[`OTPSA_ST_LO_TEST] = lower_test_fail;
            rd_val[`OTPSA_ST_UP_PROG] = upper_prog_fail;
            rd_val[`OTPSA_ST_LO_PROG] = lower_prog_fail;
            rd_val[`OTPSA_ST_FIFO_HI:`OTPSA_ST_FIFO_LO] = fifo_words;
            rd_val[`OTPSA_ST_AUTO_IDLE] = auto_idle;
            rd_val[`OTPSA_ST_TEST_FAIL] = test_fail_flag;
            rd_val[`OTPSA_ST_TEST_IDLE] = test_idle;
            rd_val[`OTPSA_ST_PROG_FAIL] = prog_fail_flag;
            rd_val[`OTPSA_ST_BITPROG_IDLE] = bitprog_idle;
         end
         `OTPSA_ADDR_DMA_BASE: rd_val = {dma_addr[31:2], 2'h0};
         `OTPSA_ADDR_CELL_ADDR: rd_val[12:0] = cell_addr;
         `OTPSA_ADDR_XFER_LEN: rd_val[12:0] = xfer_len;
         `OTPSA_ADDR_CONTROL: begin
            rd_val[`OTPSA_CTL_MODE_HI:`OTPSA_CTL_MODE_LO] = mode;
            rd_val[`OTPSA_CTL_PORT_SEL] = port_sel;
         end
         `OTPSA_ADDR_IRQ_STATUS: rd_val[2:0] = irq_status;
         `OTPSA_ADDR_IRQ_MASK: rd_val[2:0] = irq_mask;
         default: rd_val = `OTPSA_RST_ZERO;
      endcase
   end

   // ---------------------------------------------------------------
   // axi4-lite write channels, address and data in either order
   // ---------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OTPSA_RESP_OKAY;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= `OTPSA_RST_ZERO;
         w_data <= `OTPSA_RST_ZERO;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_full <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_full <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // bvalid gates do_write, so each address and data pair commits once
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? `OTPSA_RESP_OKAY : `OTPSA_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // axi4-lite read channel, answer one cycle after the address
   // ---------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `OTPSA_RST_ZERO;
         s_axi_rresp <= `OTPSA_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            // data frozen at the address edge; later status moves need a new read
            s_axi_rdata <= rd_val;
            s_axi_rresp <= mapped(s_axi_araddr) ? `OTPSA_RESP_OKAY : `OTPSA_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_addr <= `OTPSA_RST_ZERO;
         mode <= `OTPSA_MODE_STANDBY;
         port_sel <= 1'b0;
         irq_mask <= 3'h0;
         irq_status <= 3'h0;
         xfer_len <= 13'h0000;
         irq <= 1'b0;
      end else begin
         if (do_write && (aw_addr == `OTPSA_ADDR_DMA_BASE)) begin
            dma_addr <= {dma_merged[31:2], 2'h0};
         end
         if (mode_chg) begin
            mode <= new_mode;
         end
         if (wr_ctl && mode_ok) begin
            port_sel <= new_port_sel;
         end
         if (do_write && (aw_addr == `OTPSA_ADDR_IRQ_MASK)) begin
            irq_mask <= wr_val[2:0];
         end
         // a new event beats a same-cycle write-one-to-clear
         if (do_write && (aw_addr == `OTPSA_ADDR_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~wr_val[2:0]) | events;
         end else begin
            irq_status <= irq_status | events;
         end
         // registered so the pin is a clean flop output, one cycle behind status
         irq <= |(irq_status & irq_mask);
         if (do_write && (aw_addr == `OTPSA_ADDR_XFER_LEN)) begin
            xfer_len <= len_merged[12:0];
         end else if (mirror_active && word_done && (xfer_len != 13'h0000)) begin
            xfer_len <= xfer_len - 13'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // automatic read/program sequencer
   // ---------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= S_IDLE;
         cell_req <= 1'b0;
         cell_write <= 1'b0;
         cell_addr <= 13'h0000;
         remaining <= 14'h0000;
         auto_idle <= `OTPSA_RST_IDLE;
      end else begin
         case (state)
            S_IDLE: begin
               cell_req <= 1'b0;
               // the cell address only takes writes while no run is active
               if (do_write && (aw_addr == `OTPSA_ADDR_CELL_ADDR)) begin
                  cell_addr <= wr_val[12:0];
               end
               if (start_auto) begin
                  state <= S_RUN;
                  auto_idle <= 1'b0;
                  cell_write <= (new_mode == `OTPSA_MODE_AUTO_PROG);
                  // port-fed programming takes no count from the length register, though mirroring still counts it down per word
                  if (new_port_sel && (new_mode == `OTPSA_MODE_AUTO_PROG)) begin
                     remaining <= 14'h0000;
                  end else begin
                     remaining <= {1'b0, xfer_len} + 14'h0001;
                  end
               end
            end
            S_RUN: begin
               if (mode_chg && (new_mode == `OTPSA_MODE_STANDBY)) begin
                  state <= S_IDLE;
                  cell_req <= 1'b0;
                  auto_idle <= 1'b1;
                  remaining <= 14'h0000;
                  // a word that finishes on the abort edge still moves the address
                  if (word_done) begin
                     cell_addr <= cell_addr + 13'h0001;
                  end
               end else if (word_done) begin
                  cell_req <= 1'b0;
                  cell_addr <= cell_addr + 13'h0001;
                  if (!prog_via_port) begin
                     remaining <= remaining - 14'h0001;
                  end
                  if (last_word) begin
                     state <= S_IDLE;
                     auto_idle <= 1'b1;
                  end
               end else if (!cell_req && fifo_ok) begin
                  // fifo gate keeps a read from overrunning or a program from starving
                  cell_req <= 1'b1;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // programming and test result flags
   // ---------------------------------------------------------------
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bitprog_idle <= `OTPSA_RST_IDLE;
         test_idle <= `OTPSA_RST_IDLE;
         prog_fail_flag <= 1'b0;
         upper_prog_fail <= 1'b0;
         lower_prog_fail <= 1'b0;
         test_fail_flag <= 1'b0;
         upper_test_fail <= 1'b0;
         lower_test_fail <= 1'b0;
         fifo_words <= 4'h0;
      end else begin
         // busy inputs come from same-clock logic, so no synchroniser is needed
         bitprog_idle <= !prog_busy;
         test_idle <= !test_busy;
         fifo_words <= fifo_level;
         // each result replaces the last, so it may toggle word by word
         if (prog_result_valid) begin
            prog_fail_flag <= prog_fail_upper || prog_fail_lower;
            upper_prog_fail <= prog_fail_upper;
            lower_prog_fail <= prog_fail_lower;
         end
         if (test_result_valid) begin
            test_fail_flag <= test_fail_upper || test_fail_lower;
            upper_test_fail <= test_fail_upper;
            lower_test_fail <= test_fail_lower;
         end
      end
   end

endmodule // otpsa_status
